// ==== hw/dgp_gpio.sv ====
// dual general-purpose port with change detection, AXI4-Lite slave
`timescale 1ns/1ns
module dgp_gpio (
  input wire logic clk_sys,
  input wire logic reset,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // first port pins
  input wire logic [4:0] first_port_in,
  output logic [4:0] first_port_out,
  output logic [4:0] first_port_oe_n,
  // second port pins
  input wire logic [7:0] second_port_in,
  output logic [7:0] second_port_out,
  output logic [7:0] second_port_oe_n,
  output logic [7:0] second_port_pullup,
  // alternate functions
  input wire logic serial_prog_mode,
  output logic timer_clock_in,
  output logic external_interrupt,
  output logic serial_prog_clock,
  output logic serial_prog_data,
  output logic port_change_flag,
  output logic wake_request
);

  // ************************************************************
  // pin synchroniser
  // ************************************************************
  logic [12:0] pins_sync; // second port high, first port low
  logic [4:0] first_pins; // first port levels as read
  logic [7:0] second_pins; // second port levels as read
  dgp_sync #(
    .WIDTH(dgp_pkg::PIN_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in({second_port_in, first_port_in}),
    .sync_out(pins_sync)
  );
  assign first_pins = pins_sync[4:0];
  assign second_pins = pins_sync[12:5];

  // ************************************************************
  // helper functions
  // ************************************************************
  // register index from a byte address
  function automatic logic [7:0] addr_index(input logic [11:0] addr);
    addr_index = addr[9:2];
  endfunction : addr_index

  // known register test
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == dgp_pkg::IDX_FIRST_PORT_DATA) ||
                (idx == dgp_pkg::IDX_SECOND_PORT_DATA) ||
                (idx == dgp_pkg::IDX_OPTION) ||
                (idx == dgp_pkg::IDX_FIRST_PORT_DIRECTION) ||
                (idx == dgp_pkg::IDX_SECOND_PORT_DIRECTION) ||
                (idx == dgp_pkg::IDX_CHANGE_STATUS);
  endfunction : is_mapped

  // byte merge: unstrobed lane keeps the sampled pin levels
  function automatic logic [7:0] rmw_merge(input logic [7:0] pins,
                                           input logic [31:0] wdata,
                                           input logic lane);
    rmw_merge = lane ? wdata[7:0] : pins;
  endfunction : rmw_merge

  // ************************************************************
  // write channel state
  // ************************************************************
  logic aw_held; // write address captured
  logic w_held; // write data captured
  logic [7:0] aw_idx; // captured write index
  logic [31:0] w_data; // captured write data
  logic w_lane0; // byte lane 0 strobe
  logic next_aw_held;
  logic next_w_held;
  logic [7:0] next_aw_idx;
  logic [31:0] next_w_data;
  logic next_w_lane0;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic do_write; // both halves present, commit now

  // ************************************************************
  // write channel next values
  // ************************************************************
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_idx = aw_idx;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    do_write = aw_held && w_held && !s_axi_bvalid;
    // address taken in its own cycle
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_idx = addr_index(s_axi_awaddr);
    end
    // data taken in its own cycle
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_lane0 = s_axi_wstrb[0];
    end
    // commit and answer
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_mapped(aw_idx) ? dgp_pkg::RESP_OKAY : dgp_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  // write channel registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= '0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dgp_pkg::RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_idx <= next_aw_idx;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  logic [4:0] first_latch; // first port output latch
  logic [7:0] second_latch; // second port output latch
  logic [4:0] first_dir; // 1 = input
  logic [7:0] second_dir; // 1 = input
  logic [7:0] option_reg; // bit 7 is pull-up enable, low active
  logic [3:0] change_ref; // reference for monitored pins
  logic flag; // port change flag
  logic [4:0] next_first_latch;
  logic [7:0] next_second_latch;
  logic [4:0] next_first_dir;
  logic [7:0] next_second_dir;
  logic [7:0] next_option_reg;
  logic [3:0] next_change_ref;
  logic next_flag;
  logic [3:0] mismatch; // per monitored pin
  logic do_read; // read accepted this cycle
  logic [7:0] rd_idx; // index of read request
  logic [7:0] first_merged; // first port write merged with sampled pins

  assign rd_idx = addr_index(s_axi_araddr);
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign first_merged = rmw_merge({3'h0, first_pins}, w_data, w_lane0);

  // ************************************************************
  // control register next values
  // ************************************************************
  always_comb begin
    next_first_latch = first_latch;
    next_second_latch = second_latch;
    next_first_dir = first_dir;
    next_second_dir = second_dir;
    next_option_reg = option_reg;
    next_change_ref = change_ref;
    next_flag = flag;
    // only input pins seven to four compare
    mismatch = (second_pins[7:4] ^ change_ref) & second_dir[7:4];
    if (do_write && w_lane0) begin
      unique case (aw_idx)
        dgp_pkg::IDX_FIRST_PORT_DIRECTION: next_first_dir = w_data[4:0];
        dgp_pkg::IDX_SECOND_PORT_DIRECTION: next_second_dir = w_data[7:0];
        dgp_pkg::IDX_OPTION: next_option_reg = w_data[7:0];
        dgp_pkg::IDX_CHANGE_STATUS: next_flag = w_data[dgp_pkg::FLAG_BIT];
        default: begin
        end
      endcase
    end
    // port writes merge with sampled pin levels
    if (do_write) begin
      if (aw_idx == dgp_pkg::IDX_FIRST_PORT_DATA) begin
        next_first_latch = first_merged[4:0];
      end
      if (aw_idx == dgp_pkg::IDX_SECOND_PORT_DATA) begin
        next_second_latch = rmw_merge(second_pins, w_data, w_lane0);
        next_change_ref = second_pins[7:4];
      end
    end
    // a read of the second port recaptures the reference
    if (do_read && rd_idx == dgp_pkg::IDX_SECOND_PORT_DATA) begin
      next_change_ref = second_pins[7:4];
    end
    // set beats a same-cycle clear
    if (|mismatch) begin
      next_flag = 1'b1;
    end
  end

  // control registers with reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      first_dir <= dgp_pkg::RST_FIRST_DIRECTION;
      second_dir <= dgp_pkg::RST_SECOND_DIRECTION;
      option_reg <= dgp_pkg::RST_OPTION;
      change_ref <= '0;
      flag <= 1'b0;
    end else begin
      first_dir <= next_first_dir;
      second_dir <= next_second_dir;
      option_reg <= next_option_reg;
      change_ref <= next_change_ref;
      flag <= next_flag;
    end
  end

  // output latches keep their content through reset
  always_ff @(posedge clk_sys) begin
    first_latch <= next_first_latch;
    second_latch <= next_second_latch;
  end

  // ************************************************************
  // read channel
  // ************************************************************
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;
  logic next_arready;
  // read data mux and handshake
  always_comb begin
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_rvalid = s_axi_rvalid;
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp = dgp_pkg::RESP_OKAY;
      unique case (rd_idx)
        dgp_pkg::IDX_FIRST_PORT_DATA: next_rdata = {27'h0, first_pins};
        dgp_pkg::IDX_SECOND_PORT_DATA: next_rdata = {24'h0, second_pins};
        dgp_pkg::IDX_OPTION: next_rdata = {24'h0, option_reg};
        dgp_pkg::IDX_FIRST_PORT_DIRECTION: next_rdata = {27'h0, first_dir};
        dgp_pkg::IDX_SECOND_PORT_DIRECTION: next_rdata = {24'h0, second_dir};
        dgp_pkg::IDX_CHANGE_STATUS: next_rdata = {31'h0, flag};
        default: begin
          // unmapped address
          next_rdata = 32'h0000_0000;
          next_rresp = dgp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;
  end

  // read channel registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= dgp_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= next_arready;
    end
  end

  // ************************************************************
  // pin drivers and alternate functions
  // ************************************************************
  logic [4:0] next_first_out;
  logic [4:0] next_first_oe_n;
  logic [7:0] next_second_out;
  logic [7:0] next_second_oe_n;
  logic [7:0] next_pullup;
  logic next_ext_int;
  logic next_prog_clk;
  logic next_prog_data;
  logic next_timer_clk;
  // driver enables from latches and directions
  always_comb begin
    next_first_out = first_latch;
    next_first_oe_n = first_dir;
    // open-drain bit only ever pulls low
    next_first_out[dgp_pkg::OD_BIT] = 1'b0;
    next_first_oe_n[dgp_pkg::OD_BIT] = first_dir[dgp_pkg::OD_BIT] ||
                                       first_latch[dgp_pkg::OD_BIT];
    next_second_out = second_latch;
    next_second_oe_n = second_dir;
    // global enable is low active; outputs never pulled
    next_pullup = {8{~option_reg[dgp_pkg::PULLUP_N_BIT]}} & second_dir;
    next_timer_clk = first_pins[dgp_pkg::OD_BIT];
    next_ext_int = second_pins[dgp_pkg::EXT_INT_BIT];
    next_prog_clk = serial_prog_mode && second_pins[dgp_pkg::PROG_CLK_BIT];
    next_prog_data = serial_prog_mode && second_pins[dgp_pkg::PROG_DATA_BIT];
  end

  // pin registers, released pins after reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      first_port_out <= '0;
      first_port_oe_n <= dgp_pkg::RST_FIRST_DIRECTION;
      second_port_out <= '0;
      second_port_oe_n <= dgp_pkg::RST_SECOND_DIRECTION;
      second_port_pullup <= '0;
      timer_clock_in <= 1'b0;
      external_interrupt <= 1'b0;
      serial_prog_clock <= 1'b0;
      serial_prog_data <= 1'b0;
      port_change_flag <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      first_port_out <= next_first_out;
      first_port_oe_n <= next_first_oe_n;
      second_port_out <= next_second_out;
      second_port_oe_n <= next_second_oe_n;
      second_port_pullup <= next_pullup;
      timer_clock_in <= next_timer_clk;
      external_interrupt <= next_ext_int;
      serial_prog_clock <= next_prog_clk;
      serial_prog_data <= next_prog_data;
      port_change_flag <= flag;
      wake_request <= flag;
    end
  end

endmodule : dgp_gpio

// ==== hw/dgp_pkg.sv ====
// constants shared by the dual general-purpose port block
package dgp_pkg;

  // ************************************************************
  // register indices, byte address is four times the index
  // ************************************************************
  localparam logic [7:0] IDX_FIRST_PORT_DATA = 8'h05;
  localparam logic [7:0] IDX_SECOND_PORT_DATA = 8'h06;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_FIRST_PORT_DIRECTION = 8'h85;
  localparam logic [7:0] IDX_SECOND_PORT_DIRECTION = 8'h86;
  localparam logic [7:0] IDX_CHANGE_STATUS = 8'h90;

  // ************************************************************
  // widths and field positions
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam int FIRST_W = 5;
  localparam int SECOND_W = 8;
  localparam int PIN_W = 13;
  localparam int OD_BIT = 4;
  localparam int PULLUP_N_BIT = 7;
  localparam int EXT_INT_BIT = 0;
  localparam int PROG_CLK_BIT = 6;
  localparam int PROG_DATA_BIT = 7;
  localparam int CHANGE_LO = 4;
  localparam int FLAG_BIT = 0;

  // ************************************************************
  // values after reset
  // ************************************************************
  localparam logic [4:0] RST_FIRST_DIRECTION = 5'h1F;
  localparam logic [7:0] RST_SECOND_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_OPTION = 8'hFF;

  // ************************************************************
  // bus answers
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : dgp_pkg

// ==== hw/dgp_sync.sv ====
// two-flop synchroniser for the port pin inputs
`timescale 1ns/1ns
module dgp_sync #(
  parameter int WIDTH = 13
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // first stage, read only by the second stage
  logic [WIDTH-1:0] stage1;

  // ************************************************************
  // two registers in a row
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : dgp_sync

// ==== tb/dgp_gpio_monitor.sv ====
// concurrent checks on the pins and read bus of the dual port block
`timescale 1ns/1ns
module dgp_gpio_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [4:0] first_port_in,
  input wire logic [4:0] first_port_out,
  input wire logic [7:0] second_port_in,
  input wire logic [7:0] second_port_oe_n,
  input wire logic [7:0] second_port_pullup,
  input wire logic serial_prog_mode,
  input wire logic timer_clock_in,
  input wire logic external_interrupt,
  input wire logic serial_prog_clock,
  input wire logic serial_prog_data,
  input wire logic port_change_flag,
  input wire logic wake_request
);
  // ****************************************
  // helper state
  // ****************************************
  logic [7:0] rd_idx; // index of the read under way
  logic [7:0] next_rd_idx;
  logic [2:0] since_rst; // edges since reset, saturating
  logic [2:0] next_since_rst;

  // tracks the read index and the time since reset
  always_comb begin
    next_rd_idx = rd_idx;
    if (s_axi_arvalid && s_axi_arready) next_rd_idx = s_axi_araddr[9:2];
    next_since_rst = since_rst;
    if (reset) next_since_rst = 3'h0;
    else if (since_rst != 3'h7) next_since_rst = since_rst + 3'h1;
  end

  // registers the helper state
  always_ff @(posedge clk_sys) begin
    rd_idx <= next_rd_idx;
    since_rst <= next_since_rst;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ****************************************
  // assertions
  // ****************************************
  a_od_low: assert property (first_port_out[dgp_pkg::OD_BIT] == 1'b0)
    else $error("open-drain bit drove high");
  a_reset_state: assert property (disable iff (1'b0) reset |=>
    second_port_oe_n == 8'hFF && second_port_pullup == 8'h00 && !port_change_flag)
    else $error("pins not released by reset");
  a_pullup_out: assert property ((second_port_pullup & ~second_port_oe_n) == 8'h00)
    else $error("pull-up on a driven pin");
  a_timer_clk: assert property (since_rst >= 3'h4 |->
    timer_clock_in == $past(first_port_in[dgp_pkg::OD_BIT], 3))
    else $error("timer clock does not follow bit 4");
  a_ext_int: assert property (since_rst >= 3'h4 |->
    external_interrupt == $past(second_port_in[dgp_pkg::EXT_INT_BIT], 3))
    else $error("external interrupt does not follow bit 0");
  a_prog_idle: assert property (!serial_prog_mode [*4] |->
    !serial_prog_clock && !serial_prog_data)
    else $error("programming lines active outside mode");
  a_wake_flag: assert property (wake_request == port_change_flag)
    else $error("wake request differs from change flag");
  a_read_upper: assert property (s_axi_rvalid &&
    (rd_idx == dgp_pkg::IDX_FIRST_PORT_DATA || rd_idx == dgp_pkg::IDX_FIRST_PORT_DIRECTION)
    |-> s_axi_rdata[31:5] == 27'h0)
    else $error("first port upper bits not zero");
endmodule : dgp_gpio_monitor

bind dgp_gpio dgp_gpio_monitor dgp_gpio_monitor_inst (
  .clk_sys, .reset, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .first_port_in, .first_port_out, .second_port_in, .second_port_oe_n,
  .second_port_pullup, .serial_prog_mode, .timer_clock_in, .external_interrupt,
  .serial_prog_clock, .serial_prog_data, .port_change_flag, .wake_request
);

// ==== tb/dgp_gpio_tb_top.sv ====
// self-checking bench for the dual general-purpose port block
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dgp_gpio_tb_top;
  // ****************************************
  // addresses, stimulus and observed pins
  // ****************************************
  localparam logic [11:0] A_FD = {2'h0, dgp_pkg::IDX_FIRST_PORT_DATA, 2'h0};
  localparam logic [11:0] A_SD = {2'h0, dgp_pkg::IDX_SECOND_PORT_DATA, 2'h0};
  localparam logic [11:0] A_OPT = {2'h0, dgp_pkg::IDX_OPTION, 2'h0};
  localparam logic [11:0] A_FDIR = {2'h0, dgp_pkg::IDX_FIRST_PORT_DIRECTION, 2'h0};
  localparam logic [11:0] A_SDIR = {2'h0, dgp_pkg::IDX_SECOND_PORT_DIRECTION, 2'h0};
  localparam logic [11:0] A_CHG = {2'h0, dgp_pkg::IDX_CHANGE_STATUS, 2'h0};
  localparam logic [11:0] A_BAD = 12'h100; // nothing mapped here
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, serial_prog_mode = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic [4:0] first_port_in, first_port_out, first_port_oe_n;
  logic [4:0] fp_ext_en = 5'h00, fp_ext_val = 5'h00;
  logic [7:0] second_port_in, second_port_out, second_port_oe_n, second_port_pullup;
  logic [7:0] sp_ext_en = 8'h00, sp_ext_val = 8'h00;
  logic timer_clock_in, external_interrupt, serial_prog_clock, serial_prog_data;
  logic port_change_flag, wake_request;
  int n_fail = 0;
  int n_compared = 0;

  dgp_gpio dgp_gpio_inst (
    .clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .first_port_in, .first_port_out, .first_port_oe_n, .second_port_in,
    .second_port_out, .second_port_oe_n, .second_port_pullup, .serial_prog_mode,
    .timer_clock_in, .external_interrupt, .serial_prog_clock, .serial_prog_data,
    .port_change_flag, .wake_request
  );
  dgp_pins_model dgp_pins_model_inst (
    .clk_sys, .first_port_out, .first_port_oe_n, .fp_ext_en, .fp_ext_val, .first_port_in,
    .second_port_out, .second_port_oe_n, .second_port_pullup, .sp_ext_en, .sp_ext_val,
    .second_port_in
  );

  // 20 MHz system clock
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  // each channel released at the edge it is taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    @(posedge clk_sys); // idle edge: a following call never re-drives a strobe at once
    if (i == 50) begin
      n_fail++;
      summarize();
    end
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk_sys); // idle edge: a following call never re-drives a strobe at once
    if (i == 50) begin
      n_fail++;
      summarize();
    end
  endtask : axi_read

  task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic s);
    axi_write(a, {24'h0, v}, {3'h0, s});
    `CHK(r, dgp_pkg::RESP_OKAY);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    axi_read(a);
    `CHK(r, dgp_pkg::RESP_OKAY);
    `CHK(d, {24'h0, e});
  endtask : rd_chk

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    idle(16);
    reset <= 1'b0;
    idle(2);
    // reset values and an unmapped place
    rd_chk(A_FDIR, 8'h1F);
    rd_chk(A_SDIR, 8'hFF);
    rd_chk(A_OPT, 8'hFF);
    `CHK(second_port_pullup, 8'h00);
    `CHK(first_port_oe_n, 5'h1F);
    axi_read(A_BAD);
    `CHK(r, dgp_pkg::RESP_SLVERR);
    axi_write(A_BAD, 32'h0, 4'h1);
    `CHK(r, dgp_pkg::RESP_SLVERR);
    $display("test reset values done");
    // first port driving, open drain bit 4
    wr(A_FDIR, 8'h00, 1'b1);
    wr(A_FD, 8'hFA, 1'b1);
    idle(4);
    `CHK(first_port_out[3:0], 4'hA);
    `CHK(first_port_oe_n, 5'h10);
    rd_chk(A_FD, 8'h1A);
    wr(A_FD, 8'h00, 1'b1);
    idle(5);
    `CHK(first_port_oe_n, 5'h00);
    `CHK(timer_clock_in, 1'b0);
    wr(A_FDIR, 8'hFF, 1'b1);
    rd_chk(A_FDIR, 8'h1F);
    $display("test first port output done");
    // pins read back, an unstrobed write stores sampled pins
    fp_ext_en <= 5'h1F;
    fp_ext_val <= 5'h15;
    idle(5);
    wr(A_FD, 8'h0C, 1'b1);
    rd_chk(A_FD, 8'h15);
    `CHK(timer_clock_in, 1'b1);
    wr(A_FD, 8'h00, 1'b0);
    fp_ext_en <= 5'h00;
    wr(A_FDIR, 8'h00, 1'b1);
    idle(4);
    `CHK(first_port_out[3:0], 4'h5);
    `CHK(first_port_oe_n, 5'h10);
    $display("test read-modify-write done");
    // second port and weak pull-ups
    wr(A_SD, 8'h05, 1'b1);
    wr(A_SDIR, 8'hF0, 1'b1);
    wr(A_OPT, 8'h7F, 1'b1);
    idle(4);
    `CHK(second_port_pullup, 8'hF0);
    `CHK(second_port_oe_n, 8'hF0);
    `CHK(second_port_out[3:0], 4'h5);
    rd_chk(A_SD, 8'hF5);
    wr(A_OPT, 8'hFF, 1'b1);
    idle(4);
    `CHK(second_port_pullup, 8'h00);
    $display("test pull-ups done");
    // change detection on the upper inputs
    sp_ext_en <= 8'hFF;
    sp_ext_val <= 8'h00;
    idle(5);
    axi_read(A_SD);
    wr(A_CHG, 8'h00, 1'b1);
    idle(2);
    `CHK(port_change_flag, 1'b0);
    sp_ext_val <= 8'h20;
    idle(8);
    `CHK(port_change_flag, 1'b1);
    `CHK(wake_request, 1'b1);
    wr(A_CHG, 8'h00, 1'b1);
    idle(2);
    `CHK(port_change_flag, 1'b1);
    axi_read(A_SD);
    wr(A_CHG, 8'h00, 1'b1);
    idle(2);
    `CHK(port_change_flag, 1'b0);
    wr(A_SDIR, 8'hFF, 1'b1);
    sp_ext_val <= 8'h2A;
    idle(8);
    `CHK(port_change_flag, 1'b0);
    wr(A_SD, 8'h80, 1'b1);
    wr(A_SDIR, 8'h7F, 1'b1);
    idle(8);
    `CHK(port_change_flag, 1'b0);
    $display("test change detection done");
    // alternate functions of the second port
    serial_prog_mode <= 1'b1;
    sp_ext_val <= 8'h41;
    idle(8);
    `CHK(serial_prog_clock, 1'b1);
    `CHK(serial_prog_data, 1'b1);
    `CHK(external_interrupt, 1'b1);
    serial_prog_mode <= 1'b0;
    idle(8);
    `CHK(serial_prog_clock, 1'b0);
    `CHK(serial_prog_data, 1'b0);
    $display("test alternate functions done");
    // a second reset restores directions and keeps the latches
    reset <= 1'b1;
    idle(2);
    reset <= 1'b0;
    idle(2);
    rd_chk(A_FDIR, 8'h1F);
    wr(A_FDIR, 8'h00, 1'b1);
    idle(4);
    `CHK(first_port_out[3:0], 4'h5);
    $display("test second reset done");
    summarize();
  end
endmodule : dgp_gpio_tb_top

// ==== tb/dgp_pins_model.sv ====
// board-side model of the port pins, keypad lines and pull resistors
`timescale 1ns/1ns
module dgp_pins_model (
  input wire logic clk_sys,
  input wire logic [4:0] first_port_out,
  input wire logic [4:0] first_port_oe_n,
  input wire logic [4:0] fp_ext_en,
  input wire logic [4:0] fp_ext_val,
  output logic [4:0] first_port_in,
  input wire logic [7:0] second_port_out,
  input wire logic [7:0] second_port_oe_n,
  input wire logic [7:0] second_port_pullup,
  input wire logic [7:0] sp_ext_en,
  input wire logic [7:0] sp_ext_val,
  output logic [7:0] second_port_in
);
  // ****************************************
  // wire levels
  // ****************************************
  logic float_pat = 1'b0; // an undriven line wanders every cycle

  // toggles the level seen on lines nobody drives
  always_ff @(posedge clk_sys) begin
    float_pat <= ~float_pat;
  end

  // device drive wins, then keypad drive, then pull resistors
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (!first_port_oe_n[i]) first_port_in[i] = (i == 4) ? 1'b0 : first_port_out[i];
      else if (fp_ext_en[i]) first_port_in[i] = fp_ext_val[i];
      else first_port_in[i] = (i == 4) ? 1'b1 : float_pat; // board pull-up on bit 4
    end
    for (int i = 0; i < 8; i++) begin
      if (!second_port_oe_n[i]) second_port_in[i] = second_port_out[i];
      else if (sp_ext_en[i]) second_port_in[i] = sp_ext_val[i];
      else second_port_in[i] = second_port_pullup[i] ? 1'b1 : float_pat;
    end
  end
endmodule : dgp_pins_model
